// [bench/flash_text_pixel_command_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module flash_text_pixel_command_unit_bench;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic req_valid, req_ready, req_arg, rd_valid, rej, fb_we, fb_re, anim_valid;
  ftp_pkg::ftp_op_t req_op;
  logic [3:0] req_idx;
  logic [9:0] req_x, req_y, fb_x, fb_y;
  logic [23:0] req_color, rd_color, c;
  logic [1:0] req_lvl;
  logic [15:0] fb_wdata, fb_rdata, anim_color, last_anim, fg_m, bg_m;
  logic [15:0] fb [int];
  logic [31:0] sv [4];
  bit sv_ok [4];
  int error_cnt, checks_done, rej_cnt, anim_cnt, cyc;
  ftp_link_if link ();
  ftp_host_end ftp_host_end_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .link(link),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_op(req_op), .i_req_idx(req_idx),
    .i_req_arg(req_arg), .i_req_x0(req_x), .i_req_y0(req_y), .i_req_x1(req_x),
    .i_req_y1(req_y), .i_req_color(req_color), .i_req_level(req_lvl),
    .o_rd_valid(rd_valid), .o_rd_color(rd_color), .o_rej(rej));
  ftp_dev_end #(.CYC_PER_MS(10)) ftp_dev_end_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .link(link), .o_fb_we(fb_we), .o_fb_re(fb_re), .o_fb_x(fb_x), .o_fb_y(fb_y),
    .o_fb_wdata(fb_wdata), .o_fb_pen(), .i_fb_rdata(fb_rdata), .o_anim_valid(anim_valid),
    .o_anim_slot(), .o_anim_color(anim_color), .o_err());
  ftp_link_asserts ftp_link_asserts_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready), .cmd_op(link.cmd_op),
    .cmd_idx(link.cmd_idx), .rsp_valid(link.rsp_valid), .rsp_char(link.rsp_char));
  initial forever #50 i_sys_clk = ~i_sys_clk;
  // ==========================================================
  // Frame store, monitors and timeout
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (fb_we) fb[{fb_x, fb_y}] = fb_wdata;
    if (fb_re) fb_rdata <= fb[{fb_x, fb_y}];
    if (anim_valid) last_anim <= anim_color;
    if (anim_valid) anim_cnt++;
    if (rej) rej_cnt++;
    if (cyc == 20000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  task automatic chk(string n, logic [23:0] e, logic [23:0] s);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One request, drawing-state model kept in step
  task automatic req(ftp_pkg::ftp_op_t op, logic [3:0] idx, logic arg, logic [23:0] cl,
                     logic [1:0] l);
    while (req_ready !== 1'b1) @(posedge i_sys_clk) #1;
    req_op = op;
    req_idx = idx;
    req_arg = arg;
    req_color = cl;
    req_lvl = l;
    req_valid = 1'b1;
    @(posedge i_sys_clk) #1;
    req_valid = 1'b0;
    case (op)
      ftp_pkg::SET_FG_CMD: fg_m = cl[15:0];
      ftp_pkg::SET_BG_CMD: bg_m = cl[15:0];
      ftp_pkg::DRAW_STATE_SAVE_CMD: {sv_ok[l], sv[l]} = {1'b1, fg_m, bg_m};
      ftp_pkg::DRAW_STATE_RESTORE_CMD: {fg_m, bg_m} = sv_ok[l] ? sv[l] : 32'hFFFF0000;
      default: ;
    endcase
  endtask : req
  task automatic rd(ftp_pkg::ftp_op_t op, logic [23:0] e);
    req(op, 4'h0, 1'b0, 24'h000000, 2'h0);
    repeat (30) if (rd_valid !== 1'b1) @(posedge i_sys_clk) #1;
    chk("read", e, rd_color);
  endtask : rd
  task automatic fl(ftp_pkg::ftp_op_t op, logic [3:0] idx, logic arg);
    req(op, idx, arg, 24'h000000, 2'h0);
    repeat (6) @(posedge i_sys_clk) #1;
  endtask : fl
  // ==========================================================
  // Main sequence
  initial begin
    {req_valid, req_arg, req_idx, req_x, req_y, req_color, req_lvl} = '0;
    req_op = ftp_pkg::SET_FG_CMD;
    fg_m = 16'hFFFF;
    bg_m = 16'h0000;
    void'($urandom(32'hC2F2));
    repeat (16) @(posedge i_sys_clk);
    #1 i_rstn = 1'b1;
    req(ftp_pkg::SET_FG_CMD, 4'h0, 1'b0, 24'h001234, 2'h0);
    req(ftp_pkg::DRAW_STATE_RESTORE_CMD, 4'h0, 1'b0, 24'h000000, 2'h2);
    req(ftp_pkg::PIXEL_WRITE_SHORT_CMD, 4'h0, 1'b0, 24'h000000, 2'h0);
    rd(ftp_pkg::PIXEL_READ_SHORT_CMD, {8'h00, fg_m});
    for (int k = 0; k < 4; k++) begin
      c = 24'($urandom);
      req_x = 10'($urandom_range(1023));
      req_y = 10'($urandom_range(1023));
      req(ftp_pkg::PIXEL_WRITE_SHORT_CMD, 4'h0, 1'b1, c, 2'h0);
      rd(ftp_pkg::PIXEL_READ_SHORT_CMD, {8'h00, c[15:0]});
      req(ftp_pkg::PIXEL_WRITE_WIDE_CMD, 4'h0, 1'b1, c, 2'h0);
      rd(ftp_pkg::PIXEL_READ_WIDE_CMD, {c[23:19], 3'h0, c[15:10], 2'h0, c[7:3], 3'h0});
      req(ftp_pkg::SET_FG_CMD, 4'h0, 1'b0, ~c, 2'h0);
      req(ftp_pkg::DRAW_STATE_SAVE_CMD, 4'h0, 1'b0, 24'h000000, k[1:0]);
      req(ftp_pkg::SET_FG_CMD, 4'h0, 1'b0, c, 2'h0);
      req(ftp_pkg::DRAW_STATE_RESTORE_CMD, 4'h0, 1'b0, 24'h000000, k[1:0]);
      req(ftp_pkg::PIXEL_WRITE_SHORT_CMD, 4'h0, 1'b0, c, 2'h0);
      rd(ftp_pkg::PIXEL_READ_SHORT_CMD, {8'h00, fg_m});
    end
    req(ftp_pkg::SET_BG_CMD, 4'h0, 1'b0, c, 2'h0);
    fl(ftp_pkg::FLASH_DEFINE_CMD, 4'h9, 1'b0);
    fl(ftp_pkg::FLASH_SYNC_CMD, 4'h0, 1'b0);
    fl(ftp_pkg::FLASH_RESUME_CMD, 4'h9, 1'b0);
    chk("steps", 24'h2, anim_cnt[23:0]);
    fl(ftp_pkg::FLASH_STOP_CMD, 4'h9, 1'b1);
    chk("stop1", {8'h00, bg_m}, {8'h00, last_anim});
    fl(ftp_pkg::FLASH_RESUME_CMD, 4'h9, 1'b0);
    fl(ftp_pkg::FLASH_STOP_CMD, 4'h9, 1'b0);
    chk("stop0", {8'h00, fg_m}, {8'h00, last_anim});
    fl(ftp_pkg::FLASH_STOP_CMD, 4'hA, 1'b1);
    chk("rejects", 24'h1, rej_cnt[23:0]);
    fl(ftp_pkg::FLASH_RELEASE_CMD, 4'h9, 1'b1);
    c = 24'(anim_cnt);
    fl(ftp_pkg::FLASH_STOP_CMD, 4'h9, 1'b1);
    chk("deleted", c, anim_cnt[23:0]);
    conclude();
  end
endmodule : flash_text_pixel_command_unit_bench
`default_nettype wire

// [bench/ftp_link_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module ftp_link_asserts (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire ftp_pkg::ftp_op_t cmd_op,
  input wire logic [3:0] cmd_idx,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_char
);
  // ==========================================================
  // Link checks
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  logic tk;
  assign tk = cmd_valid && cmd_ready;
  chk_idx_range: assert property (tk && cmd_op <= ftp_pkg::FLASH_DELETE_CMD
    |-> cmd_idx <= 4'h9) else $error("flash index above nine");
  chk_hex_upper: assert property (rsp_valid |-> rsp_char inside
    {[8'h30:8'h39], [8'h41:8'h46]}) else $error("reply char not hex");
  chk_short_busy: assert property (tk && cmd_op == ftp_pkg::PIXEL_READ_SHORT_CMD
    |=> !cmd_ready [*6]) else $error("short read reopened early");
  chk_wide_busy: assert property (tk && cmd_op == ftp_pkg::PIXEL_READ_WIDE_CMD
    |=> !cmd_ready [*8]) else $error("wide read reopened early");
  chk_read_answer: assert property (tk && cmd_op == ftp_pkg::PIXEL_READ_SHORT_CMD
    |-> ##[3:5] rsp_valid) else $error("read reply late");
  chk_write_ready: assert property (tk && cmd_op == ftp_pkg::PIXEL_WRITE_SHORT_CMD
    |=> cmd_ready) else $error("pixel write stalled link");
  chk_rsp_busy: assert property (rsp_valid |-> !cmd_ready)
    else $error("reply while accepting");
  chk_define_step: assert property (tk && cmd_op == ftp_pkg::FLASH_DEFINE_CMD
    |=> !cmd_ready) else $error("define drew no step");
endmodule : ftp_link_asserts
`default_nettype wire

// [core/ftp_dev_end.sv]
// Overview of operation
// - Stop state 0 halts showing foreground text
// - Stop state 1 halts showing background erase
// - Animation index only zero through nine
// - Resume of running animation does nothing
// - Resume restarts stopped animation from held phase
// - Delete stops animation and frees its slot
// - Host stops with phase before deleting
// - Sync returns all active animations to phase zero
// - Sync restarts all timers together
// - Save captures whole drawing environment
// - One save slot per macro call level
// - Animation engine saves and restores privately
// - Restore reloads current level's save slot
// - Restore without prior save gives power-up state
// - Short pixel write without colour uses foreground
// - Short colour packed red-green-blue 5-6-5
// - Wide colour is 24-bit, two hex per channel
// - Short read replies four hex characters
// - Wide read replies six hex characters
// - Line uses foreground colour and pen width
// - Flash alternates phases, 500 ms default each
`timescale 1ns/1ps
`default_nettype none
module ftp_dev_end #(
  parameter int CYC_PER_MS = ftp_pkg::CYC_PER_MS,
  parameter int LEVELS = ftp_pkg::MACRO_LEVELS
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  ftp_link_if.dev link,
  output logic o_fb_we,
  output logic o_fb_re,
  output logic [ftp_pkg::COORD_W-1:0] o_fb_x,
  output logic [ftp_pkg::COORD_W-1:0] o_fb_y,
  output logic [15:0] o_fb_wdata,
  output logic [3:0] o_fb_pen,
  input wire logic [15:0] i_fb_rdata,
  output logic o_anim_valid,
  output logic [3:0] o_anim_slot,
  output logic [15:0] o_anim_color,
  output logic o_err
);
  localparam int NS = ftp_pkg::FLASH_SLOTS;
  localparam int CW = ftp_pkg::COORD_W;
  localparam int LW = ftp_pkg::COORD_W + 3;
  localparam int TW = ftp_pkg::TICK_W;
  localparam logic [TW-1:0] TICK_LAST = TW'(CYC_PER_MS - 1);
  localparam logic signed [LW-1:0] ONE_S = LW'(1);

  typedef enum logic [2:0] {M_IDLE, M_LINE, M_RD1, M_RD2, M_TXW, M_TX} ftp_mode_t;
  typedef enum logic [1:0] {A_IDLE, A_SAVE, A_DRAW, A_RESTORE} ftp_anim_t;

  typedef struct packed {
    ftp_mode_t mode;
    ftp_anim_t anim;
    logic ready;
    ftp_pkg::ftp_env_t env;
    ftp_pkg::ftp_env_t anim_save;
    ftp_pkg::ftp_env_t [LEVELS-1:0] save;
    logic [LEVELS-1:0] saved;
    logic [NS-1:0] defined;
    logic [NS-1:0] running;
    logic [NS-1:0] phase;
    logic [NS-1:0] pend;
    logic [NS-1:0][15:0] delay;
    logic [NS-1:0][15:0] ms_cnt;
    logic [TW-1:0] tick_cnt;
    logic [3:0] anim_slot;
    logic signed [LW-1:0] lx;
    logic signed [LW-1:0] ly;
    logic signed [LW-1:0] ex;
    logic signed [LW-1:0] ey;
    logic signed [LW-1:0] dx;
    logic signed [LW-1:0] dy;
    logic signed [LW-1:0] bres_err;
    logic sx;
    logic sy;
    logic rd_wide;
    logic fb_we;
    logic fb_re;
    logic [CW-1:0] fb_x;
    logic [CW-1:0] fb_y;
    logic [15:0] fb_wdata;
    logic [3:0] fb_pen;
    logic anim_valid;
    logic [15:0] anim_color;
    logic err_p;
    logic tx_start;
    logic [23:0] tx_data;
    logic [2:0] tx_n;
  } ftp_dev_st_t;

  ftp_dev_st_t s_r;
  ftp_dev_st_t s_nxt;
  logic tx_busy;
  logic tx_valid;
  logic [7:0] tx_char;

  always_comb begin
    logic tick;
    logic accept;
    logic idx_ok;
    logic lvl_ok;
    logic [3:0] idx;
    logic [1:0] lvl;
    logic signed [LW-1:0] e2;
    logic signed [LW-1:0] dv;
    logic signed [LW-1:0] step;
    tick = 1'b0;
    accept = link.cmd_valid && s_r.ready;
    idx = link.cmd_idx;
    lvl = link.cmd_level;
    idx_ok = idx <= ftp_pkg::FLASH_MAX_IDX;
    lvl_ok = int'(lvl) < LEVELS;
    e2 = s_r.bres_err <<< 1;
    dv = '0;
    step = '0;
    s_nxt = s_r;
    s_nxt.fb_we = 1'b0;
    s_nxt.fb_re = 1'b0;
    s_nxt.anim_valid = 1'b0;
    s_nxt.err_p = 1'b0;
    s_nxt.tx_start = 1'b0;

    // ========================================================
    // Animation step: private save, draw phase, restore
    case (s_r.anim)
      A_IDLE: begin
        if (!accept && s_r.mode == M_IDLE && s_r.pend != '0) begin
          for (int i = NS - 1; i >= 0; i--) begin
            if (s_r.pend[i]) begin
              s_nxt.anim_slot = 4'(i);
            end
          end
          s_nxt.anim = A_SAVE;
        end
      end
      A_SAVE: begin
        s_nxt.anim_save = s_r.env;
        s_nxt.anim = A_DRAW;
      end
      A_DRAW: begin
        s_nxt.env.fg = s_r.phase[s_r.anim_slot] ? s_r.env.bg : s_r.env.fg;
        s_nxt.anim_valid = 1'b1;
        s_nxt.anim_color = s_nxt.env.fg;
        s_nxt.pend[s_r.anim_slot] = 1'b0;
        s_nxt.anim = A_RESTORE;
      end
      A_RESTORE: begin
        s_nxt.env = s_r.anim_save;
        s_nxt.anim = A_IDLE;
      end
      default: s_nxt.anim = A_IDLE;
    endcase

    // ========================================================
    // Millisecond timers; a phase toggle wins over a pending clear
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + TW'(1);
    end
    for (int i = 0; i < NS; i++) begin
      if (tick && s_r.running[i]) begin
        if (s_r.ms_cnt[i] + 16'h0001 >= s_r.delay[i]) begin
          s_nxt.ms_cnt[i] = '0;
          s_nxt.phase[i] = ~s_r.phase[i];
          s_nxt.pend[i] = 1'b1;
        end else begin
          s_nxt.ms_cnt[i] = s_r.ms_cnt[i] + 16'h0001;
        end
      end
    end

    // ========================================================
    // Command execution
    if (accept) begin
      case (link.cmd_op)
        ftp_pkg::FLASH_DEFINE_CMD, ftp_pkg::FLASH_STOP_CMD, ftp_pkg::FLASH_RESUME_CMD,
        ftp_pkg::FLASH_DELETE_CMD: begin
          if (!idx_ok) begin
            s_nxt.err_p = 1'b1;
          end else if (link.cmd_op == ftp_pkg::FLASH_DEFINE_CMD) begin
            s_nxt.defined[idx] = 1'b1;
            s_nxt.running[idx] = 1'b1;
            s_nxt.phase[idx] = 1'b0;
            s_nxt.ms_cnt[idx] = '0;
            s_nxt.pend[idx] = 1'b1;
            s_nxt.delay[idx] = (link.cmd_color[15:0] == '0) ? ftp_pkg::FLASH_DEF_MS
                                                             : link.cmd_color[15:0];
          end else if (link.cmd_op == ftp_pkg::FLASH_STOP_CMD) begin
            if (s_r.defined[idx]) begin
              s_nxt.running[idx] = 1'b0;
              s_nxt.phase[idx] = link.cmd_arg;
              s_nxt.ms_cnt[idx] = '0;
              s_nxt.pend[idx] = 1'b1;
            end
          end else if (link.cmd_op == ftp_pkg::FLASH_RESUME_CMD) begin
            if (s_r.defined[idx] && !s_r.running[idx]) begin
              s_nxt.running[idx] = 1'b1;
              s_nxt.ms_cnt[idx] = '0;
            end
          end else begin
            s_nxt.defined[idx] = 1'b0;
            s_nxt.running[idx] = 1'b0;
            s_nxt.pend[idx] = 1'b0;
          end
        end
        ftp_pkg::FLASH_SYNC_CMD: begin
          s_nxt.tick_cnt = '0;
          for (int i = 0; i < NS; i++) begin
            if (s_r.running[i]) begin
              s_nxt.phase[i] = 1'b0;
              s_nxt.ms_cnt[i] = '0;
              s_nxt.pend[i] = 1'b1;
            end
          end
        end
        ftp_pkg::DRAW_STATE_SAVE_CMD: begin
          if (lvl_ok) begin
            s_nxt.save[lvl] = s_r.env;
            s_nxt.saved[lvl] = 1'b1;
          end else begin
            s_nxt.err_p = 1'b1;
          end
        end
        ftp_pkg::DRAW_STATE_RESTORE_CMD: begin
          if (lvl_ok) begin
            s_nxt.env = s_r.saved[lvl] ? s_r.save[lvl] : ftp_pkg::ENV_POWERUP;
          end else begin
            s_nxt.err_p = 1'b1;
          end
        end
        ftp_pkg::PIXEL_WRITE_SHORT_CMD, ftp_pkg::PIXEL_WRITE_WIDE_CMD: begin
          s_nxt.fb_we = 1'b1;
          s_nxt.fb_x = link.cmd_x0;
          s_nxt.fb_y = link.cmd_y0;
          s_nxt.fb_pen = ftp_pkg::PEN_SINGLE;
          if (link.cmd_op == ftp_pkg::PIXEL_WRITE_WIDE_CMD) begin
            s_nxt.fb_wdata = ftp_pkg::rgb888_to_565(link.cmd_color);
          end else begin
            s_nxt.fb_wdata = link.cmd_arg ? link.cmd_color[15:0] : s_r.env.fg;
          end
        end
        ftp_pkg::PIXEL_READ_SHORT_CMD, ftp_pkg::PIXEL_READ_WIDE_CMD: begin
          s_nxt.fb_re = 1'b1;
          s_nxt.fb_x = link.cmd_x0;
          s_nxt.fb_y = link.cmd_y0;
          s_nxt.rd_wide = link.cmd_op == ftp_pkg::PIXEL_READ_WIDE_CMD;
          s_nxt.mode = M_RD1;
        end
        ftp_pkg::LINE_DRAW_CMD: begin
          s_nxt.lx = LW'(link.cmd_x0);
          s_nxt.ly = LW'(link.cmd_y0);
          s_nxt.ex = LW'(link.cmd_x1);
          s_nxt.ey = LW'(link.cmd_y1);
          s_nxt.sx = link.cmd_x1 < link.cmd_x0;
          s_nxt.sy = link.cmd_y1 < link.cmd_y0;
          dv = s_nxt.ex - s_nxt.lx;
          s_nxt.dx = s_nxt.sx ? -dv : dv;
          dv = s_nxt.ey - s_nxt.ly;
          s_nxt.dy = s_nxt.sy ? dv : -dv;
          s_nxt.bres_err = s_nxt.dx + s_nxt.dy;
          s_nxt.mode = M_LINE;
        end
        ftp_pkg::SET_FG_CMD: s_nxt.env.fg = link.cmd_color[15:0];
        ftp_pkg::SET_BG_CMD: s_nxt.env.bg = link.cmd_color[15:0];
        ftp_pkg::SET_PEN_CMD: s_nxt.env.pen = link.cmd_color[3:0];
        ftp_pkg::CURSOR_MOVE_CMD: begin
          s_nxt.env.cur_x = link.cmd_x0;
          s_nxt.env.cur_y = link.cmd_y0;
        end
        default: s_nxt.err_p = 1'b1;
      endcase
    end

    // ========================================================
    // Line walk and pixel readback
    case (s_r.mode)
      M_IDLE: ;
      M_LINE: begin
        s_nxt.fb_we = 1'b1;
        s_nxt.fb_x = s_r.lx[CW-1:0];
        s_nxt.fb_y = s_r.ly[CW-1:0];
        s_nxt.fb_wdata = s_r.env.fg;
        s_nxt.fb_pen = s_r.env.pen;
        if (s_r.lx == s_r.ex && s_r.ly == s_r.ey) begin
          s_nxt.mode = M_IDLE;
        end else begin
          step = '0;
          if (e2 >= s_r.dy) begin
            step = s_r.dy;
            s_nxt.lx = s_r.sx ? s_r.lx - ONE_S : s_r.lx + ONE_S;
          end
          if (e2 <= s_r.dx) begin
            step = step + s_r.dx;
            s_nxt.ly = s_r.sy ? s_r.ly - ONE_S : s_r.ly + ONE_S;
          end
          s_nxt.bres_err = s_r.bres_err + step;
        end
      end
      M_RD1: s_nxt.mode = M_RD2;
      M_RD2: begin
        s_nxt.tx_start = 1'b1;
        s_nxt.tx_data = s_r.rd_wide ? ftp_pkg::rgb565_to_888(i_fb_rdata)
                                    : {8'h00, i_fb_rdata};
        s_nxt.tx_n = s_r.rd_wide ? ftp_pkg::HEX_WIDE : ftp_pkg::HEX_SHORT;
        s_nxt.mode = M_TXW;
      end
      M_TXW: s_nxt.mode = M_TX;
      M_TX: if (!tx_busy) s_nxt.mode = M_IDLE;
      default: s_nxt.mode = M_IDLE;
    endcase

    s_nxt.ready = s_nxt.mode == M_IDLE && s_nxt.anim == A_IDLE && s_nxt.pend == '0;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
      s_r.env <= ftp_pkg::ENV_POWERUP;
    end else begin
      s_r <= s_nxt;
    end
  end

  ftp_hex_tx ftp_hex_tx_i (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_start(s_r.tx_start),
    .i_data(s_r.tx_data),
    .i_count(s_r.tx_n),
    .i_ready(link.rsp_ready),
    .o_valid(tx_valid),
    .o_char(tx_char),
    .o_busy(tx_busy)
  );

  assign link.cmd_ready = s_r.ready;
  assign link.rsp_valid = tx_valid;
  assign link.rsp_char = tx_char;
  assign o_fb_we = s_r.fb_we;
  assign o_fb_re = s_r.fb_re;
  assign o_fb_x = s_r.fb_x;
  assign o_fb_y = s_r.fb_y;
  assign o_fb_wdata = s_r.fb_wdata;
  assign o_fb_pen = s_r.fb_pen;
  assign o_anim_valid = s_r.anim_valid;
  assign o_anim_slot = s_r.anim_slot;
  assign o_anim_color = s_r.anim_color;
  assign o_err = s_r.err_p;
endmodule : ftp_dev_end
`default_nettype wire

// [core/ftp_hex_tx.sv]
`timescale 1ns/1ps
`default_nettype none
// Sends the low i_count nibbles of i_data as ASCII hex, most significant first
module ftp_hex_tx (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_start,
  input wire logic [23:0] i_data,
  input wire logic [2:0] i_count,
  input wire logic i_ready,
  output logic o_valid,
  output logic [7:0] o_char,
  output logic o_busy
);
  typedef struct packed {
    logic [23:0] data;
    logic [2:0] left;
    logic valid;
    logic [7:0] chr;
  } ftp_hex_st_t;

  ftp_hex_st_t s_r;
  ftp_hex_st_t s_nxt;

  function automatic logic [7:0] to_ascii(input logic [3:0] n);
    to_ascii = (n < ftp_pkg::NIB_TEN) ? ftp_pkg::ASCII_ZERO + {4'h0, n}
                                       : ftp_pkg::ASCII_ALPHA_OFS + {4'h0, n};
  endfunction : to_ascii

  always_comb begin
    logic [23:0] sh;
    sh = '0;
    s_nxt = s_r;
    if (!s_r.valid) begin
      if (i_start) begin
        sh = i_data << {(ftp_pkg::HEX_WIDE - i_count), 2'h0};
        s_nxt.data = sh;
        s_nxt.left = i_count;
        s_nxt.valid = 1'b1;
        s_nxt.chr = to_ascii(sh[23:20]);
      end
    end else if (i_ready) begin
      if (s_r.left > 3'h1) begin
        sh = s_r.data << 4;
        s_nxt.data = sh;
        s_nxt.left = s_r.left - 3'h1;
        s_nxt.chr = to_ascii(sh[23:20]);
      end else begin
        s_nxt.valid = 1'b0;
        s_nxt.left = '0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_valid = s_r.valid;
  assign o_char = s_r.chr;
  assign o_busy = s_r.valid;
endmodule : ftp_hex_tx
`default_nettype wire

// [core/ftp_host_end.sv]
`timescale 1ns/1ps
`default_nettype none
module ftp_host_end (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  ftp_link_if.host link,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire ftp_pkg::ftp_op_t i_req_op,
  input wire logic [3:0] i_req_idx,
  input wire logic i_req_arg,
  input wire logic [ftp_pkg::COORD_W-1:0] i_req_x0,
  input wire logic [ftp_pkg::COORD_W-1:0] i_req_y0,
  input wire logic [ftp_pkg::COORD_W-1:0] i_req_x1,
  input wire logic [ftp_pkg::COORD_W-1:0] i_req_y1,
  input wire logic [23:0] i_req_color,
  input wire logic [1:0] i_req_level,
  output logic o_rd_valid,
  output logic [23:0] o_rd_color,
  output logic o_rej
);
  localparam int CW = ftp_pkg::COORD_W;

  typedef enum logic [1:0] {H_IDLE, H_SEND, H_RSP} ftp_hmode_t;

  typedef struct packed {
    ftp_hmode_t mode;
    logic ready;
    logic second;
    logic cmd_valid;
    ftp_pkg::ftp_op_t cmd_op;
    logic [3:0] cmd_idx;
    logic cmd_arg;
    logic [CW-1:0] x0;
    logic [CW-1:0] y0;
    logic [CW-1:0] x1;
    logic [CW-1:0] y1;
    logic [23:0] color;
    logic [1:0] level;
    logic rsp_rdy;
    logic [2:0] cnt;
    logic [23:0] acc;
    logic rd_valid;
    logic [23:0] rd_color;
    logic rej;
  } ftp_host_st_t;

  ftp_host_st_t s_r;
  ftp_host_st_t s_nxt;

  always_comb begin
    logic flash_op;
    logic is_read;
    logic [7:0] c;
    logic [3:0] nib;
    logic [23:0] acc;
    flash_op = i_req_op inside {ftp_pkg::FLASH_DEFINE_CMD, ftp_pkg::FLASH_STOP_CMD,
                                ftp_pkg::FLASH_RESUME_CMD, ftp_pkg::FLASH_DELETE_CMD,
                                ftp_pkg::FLASH_RELEASE_CMD};
    is_read = s_r.cmd_op inside {ftp_pkg::PIXEL_READ_SHORT_CMD, ftp_pkg::PIXEL_READ_WIDE_CMD};
    c = link.rsp_char;
    nib = (c >= ftp_pkg::ASCII_UPPER_A) ? 4'(c - ftp_pkg::ASCII_ALPHA_OFS)
                                        : 4'(c - ftp_pkg::ASCII_ZERO);
    acc = {s_r.acc[19:0], nib};
    s_nxt = s_r;
    s_nxt.rd_valid = 1'b0;
    s_nxt.rej = 1'b0;

    case (s_r.mode)
      H_IDLE: begin
        if (i_req_valid && s_r.ready) begin
          if (flash_op && i_req_idx > ftp_pkg::FLASH_MAX_IDX) begin
            s_nxt.rej = 1'b1;
          end else begin
            s_nxt.cmd_idx = i_req_idx;
            s_nxt.cmd_arg = i_req_arg;
            s_nxt.x0 = i_req_x0;
            s_nxt.y0 = i_req_y0;
            s_nxt.x1 = i_req_x1;
            s_nxt.y1 = i_req_y1;
            s_nxt.color = i_req_color;
            s_nxt.level = i_req_level;
            s_nxt.cmd_valid = 1'b1;
            s_nxt.second = i_req_op == ftp_pkg::FLASH_RELEASE_CMD;
            s_nxt.cmd_op = (i_req_op == ftp_pkg::FLASH_RELEASE_CMD) ? ftp_pkg::FLASH_STOP_CMD
                                                                    : i_req_op;
            s_nxt.mode = H_SEND;
          end
        end
      end
      H_SEND: begin
        if (link.cmd_ready) begin
          s_nxt.cmd_valid = 1'b0;
          if (s_r.second) begin
            s_nxt.second = 1'b0;
            s_nxt.cmd_valid = 1'b1;
            s_nxt.cmd_op = ftp_pkg::FLASH_DELETE_CMD;
          end else if (is_read) begin
            s_nxt.acc = '0;
            s_nxt.rsp_rdy = 1'b1;
            s_nxt.cnt = (s_r.cmd_op == ftp_pkg::PIXEL_READ_WIDE_CMD) ? ftp_pkg::HEX_WIDE
                                                                     : ftp_pkg::HEX_SHORT;
            s_nxt.mode = H_RSP;
          end else begin
            s_nxt.mode = H_IDLE;
          end
        end
      end
      H_RSP: begin
        if (link.rsp_valid) begin
          s_nxt.acc = acc;
          s_nxt.cnt = s_r.cnt - 3'h1;
          if (s_r.cnt == 3'h1) begin
            s_nxt.rd_valid = 1'b1;
            s_nxt.rd_color = acc;
            s_nxt.rsp_rdy = 1'b0;
            s_nxt.mode = H_IDLE;
          end
        end
      end
      default: s_nxt.mode = H_IDLE;
    endcase
    s_nxt.ready = s_nxt.mode == H_IDLE;
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.cmd_valid = s_r.cmd_valid;
  assign link.cmd_op = s_r.cmd_op;
  assign link.cmd_idx = s_r.cmd_idx;
  assign link.cmd_arg = s_r.cmd_arg;
  assign link.cmd_x0 = s_r.x0;
  assign link.cmd_y0 = s_r.y0;
  assign link.cmd_x1 = s_r.x1;
  assign link.cmd_y1 = s_r.y1;
  assign link.cmd_color = s_r.color;
  assign link.cmd_level = s_r.level;
  assign link.rsp_ready = s_r.rsp_rdy;
  assign o_req_ready = s_r.ready;
  assign o_rd_valid = s_r.rd_valid;
  assign o_rd_color = s_r.rd_color;
  assign o_rej = s_r.rej;
endmodule : ftp_host_end
`default_nettype wire

// [shared/ftp_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface ftp_link_if;
  logic cmd_valid;
  logic cmd_ready;
  ftp_pkg::ftp_op_t cmd_op;
  logic [3:0] cmd_idx;
  logic cmd_arg;
  logic [ftp_pkg::COORD_W-1:0] cmd_x0;
  logic [ftp_pkg::COORD_W-1:0] cmd_y0;
  logic [ftp_pkg::COORD_W-1:0] cmd_x1;
  logic [ftp_pkg::COORD_W-1:0] cmd_y1;
  logic [23:0] cmd_color;
  logic [1:0] cmd_level;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_char;

  modport dev (
    input cmd_valid, cmd_op, cmd_idx, cmd_arg, cmd_x0, cmd_y0, cmd_x1, cmd_y1,
    input cmd_color, cmd_level, rsp_ready,
    output cmd_ready, rsp_valid, rsp_char
  );
  modport host (
    output cmd_valid, cmd_op, cmd_idx, cmd_arg, cmd_x0, cmd_y0, cmd_x1, cmd_y1,
    output cmd_color, cmd_level, rsp_ready,
    input cmd_ready, rsp_valid, rsp_char
  );
endinterface : ftp_link_if
`default_nettype wire

// [shared/ftp_pkg.sv]
package ftp_pkg;

  // ==========================================================
  // Widths and counts
  localparam int COORD_W = 10;
  localparam int TICK_W = 24;
  localparam int FLASH_SLOTS = 10;
  localparam int MACRO_LEVELS = 4;
  localparam logic [3:0] FLASH_MAX_IDX = 4'h9;
  localparam logic [3:0] PEN_SINGLE = 4'h1;
  localparam logic [2:0] HEX_SHORT = 3'h4;
  localparam logic [2:0] HEX_WIDE = 3'h6;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  // Default flash phase length, 500 ms
  localparam logic [15:0] FLASH_DEF_MS = 16'h01F4;

  // ==========================================================
  // ASCII hex
  localparam logic [7:0] ASCII_ZERO = 8'h30;
  localparam logic [7:0] ASCII_ALPHA_OFS = 8'h37;
  localparam logic [7:0] ASCII_UPPER_A = 8'h41;
  localparam logic [3:0] NIB_TEN = 4'hA;

  // ==========================================================
  // Commands and drawing environment
  typedef enum logic [4:0] {
    FLASH_DEFINE_CMD, FLASH_STOP_CMD, FLASH_RESUME_CMD, FLASH_DELETE_CMD,
    FLASH_SYNC_CMD, DRAW_STATE_SAVE_CMD, DRAW_STATE_RESTORE_CMD,
    PIXEL_WRITE_SHORT_CMD, PIXEL_WRITE_WIDE_CMD, PIXEL_READ_SHORT_CMD,
    PIXEL_READ_WIDE_CMD, LINE_DRAW_CMD, SET_FG_CMD, SET_BG_CMD, SET_PEN_CMD,
    CURSOR_MOVE_CMD, FLASH_RELEASE_CMD
  } ftp_op_t;

  typedef struct packed {
    logic [15:0] fg;
    logic [15:0] bg;
    logic [3:0] pen;
    logic [1:0] line_style;
    logic [COORD_W-1:0] cur_x;
    logic [COORD_W-1:0] cur_y;
    logic [COORD_W-1:0] org_x;
    logic [COORD_W-1:0] org_y;
    logic [3:0] font;
    logic [1:0] align;
    logic [1:0] draw_mode;
  } ftp_env_t;

  localparam ftp_env_t ENV_POWERUP = '{fg: 16'hFFFF, bg: 16'h0000, pen: 4'h1, default: '0};

  // 5-6-5 to 8-8-8, channels high, low bits zero
  function automatic logic [23:0] rgb565_to_888(input logic [15:0] c);
    rgb565_to_888 = {c[15:11], 3'h0, c[10:5], 2'h0, c[4:0], 3'h0};
  endfunction : rgb565_to_888

  function automatic logic [15:0] rgb888_to_565(input logic [23:0] c);
    rgb888_to_565 = {c[23:19], c[15:10], c[7:3]};
  endfunction : rgb888_to_565

endpackage : ftp_pkg
